// [core/pncl_pkg.sv]
package pncl_pkg;

    // store word addresses, in load order
    localparam int PNCL_NUM_WORDS = 5;
    localparam logic [7:0] PNCL_W_L1 = 8'h14;
    localparam logic [7:0] PNCL_W_CPL = 8'h15;
    localparam logic [7:0] PNCL_W_VEC = 8'h16;
    localparam logic [7:0] PNCL_W_L0S = 8'h18;
    localparam logic [7:0] PNCL_W_SUP = 8'h19;
    localparam logic [39:0] PNCL_W_LIST = {PNCL_W_SUP, PNCL_W_L0S, PNCL_W_VEC,
        PNCL_W_CPL, PNCL_W_L1};

    // load-order indices
    localparam logic [2:0] PNCL_I_L1 = 3'h0;
    localparam logic [2:0] PNCL_I_CPL = 3'h1;
    localparam logic [2:0] PNCL_I_VEC = 3'h2;
    localparam logic [2:0] PNCL_I_L0S = 3'h3;
    localparam logic [2:0] PNCL_I_SUP = 3'h4;

    // field positions
    localparam int PNCL_ACC_LSB = 12;
    localparam int PNCL_SEP_LSB = 3;
    localparam int PNCL_COM_LSB = 0;
    localparam int PNCL_RESEND_BIT = 4;
    localparam int PNCL_VEC_LSB = 11;
    localparam int PNCL_MSI_MASK_BIT = 10;
    localparam int PNCL_IO_SUP_BIT = 14;
    localparam int PNCL_CSR_EN_BIT = 13;
    localparam int PNCL_SERIAL_BIT = 12;

    // reset values before the load lands, plus the vector count limit
    localparam logic [2:0] PNCL_DEF_L1_ACC = 3'h6;
    localparam logic [2:0] PNCL_DEF_L1_SEP = 3'h4;
    localparam logic [2:0] PNCL_DEF_L1_COM = 3'h4;
    localparam logic [2:0] PNCL_DEF_L0S_ACC = 3'h3;
    localparam logic [2:0] PNCL_DEF_L0S_SEP = 3'h7;
    localparam logic [2:0] PNCL_DEF_L0S_COM = 3'h5;
    localparam logic PNCL_DEF_RESEND = 1'b0;
    localparam logic [4:0] PNCL_DEF_VEC = 5'h04;
    localparam logic [4:0] PNCL_VEC_MAX = 5'h04;
    localparam logic PNCL_DEF_MSI_MASK = 1'b1;
    localparam logic PNCL_DEF_IO_SUP = 1'b1;
    localparam logic PNCL_DEF_CSR_EN = 1'b1;
    localparam logic PNCL_DEF_SERIAL = 1'b1;
    localparam logic PNCL_DEF_COMMON = 1'b0;

    // register byte addresses
    localparam logic [7:0] PNCL_A_STATUS = 8'h00;
    localparam logic [7:0] PNCL_A_DEVCAP = 8'h04;
    localparam logic [7:0] PNCL_A_LINKCAP = 8'h08;
    localparam logic [7:0] PNCL_A_MISC = 8'h0c;
    localparam logic [7:0] PNCL_A_CTRL = 8'h10;
    localparam logic [7:0] PNCL_A_CMD = 8'h14;
    localparam logic [7:0] PNCL_A_IND_ADDR = 8'h98;
    localparam logic [7:0] PNCL_A_IND_DATA = 8'h9c;

    localparam logic [1:0] PNCL_RESP_OKAY = 2'h0;
    localparam logic [1:0] PNCL_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PNCL_ST_IDLE = 2'h0,
        PNCL_ST_REQ = 2'h1,
        PNCL_ST_GAP = 2'h3,
        PNCL_ST_DONE = 2'h2
    } pncl_state_t;

endpackage : pncl_pkg

// [core/pncl_word_fetch.sv]
`timescale 1ns/1ps
module pncl_word_fetch #(
    parameter int N_WORDS = 5
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // store read port
    output logic nvm_rd_req,
    output logic [7:0] nvm_rd_addr,
    input wire logic nvm_rd_valid,
    input wire logic [15:0] nvm_rd_data,
    // fetched words
    output logic word_valid,
    output logic [2:0] word_idx,
    output logic [15:0] word_data,
    output logic load_done
);
    pncl_pkg::pncl_state_t state_q;
    logic [2:0] idx_q;
    logic last_w;
    logic [7:0] addr_w;

    assign last_w = (idx_q == 3'(N_WORDS - 1));
    assign addr_w = pncl_pkg::PNCL_W_LIST[idx_q * 8 +: 8];

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= pncl_pkg::PNCL_ST_IDLE;
            idx_q <= 3'h0;
            nvm_rd_req <= 1'b0;
            nvm_rd_addr <= 8'h00;
            word_valid <= 1'b0;
            word_idx <= 3'h0;
            word_data <= 16'h0000;
            load_done <= 1'b0;
        end else begin
            word_valid <= 1'b0;
            case (state_q)
                pncl_pkg::PNCL_ST_IDLE: begin
                    // each word is read once per reset
                    nvm_rd_req <= 1'b1;
                    nvm_rd_addr <= addr_w;
                    state_q <= pncl_pkg::PNCL_ST_REQ;
                end
                pncl_pkg::PNCL_ST_REQ: begin
                    if (nvm_rd_valid) begin
                        nvm_rd_req <= 1'b0;
                        word_valid <= 1'b1;
                        word_idx <= idx_q;
                        word_data <= nvm_rd_data;
                        state_q <= pncl_pkg::PNCL_ST_GAP;
                    end
                end
                pncl_pkg::PNCL_ST_GAP: begin
                    if (last_w) begin
                        load_done <= 1'b1;
                        state_q <= pncl_pkg::PNCL_ST_DONE;
                    end else begin
                        idx_q <= idx_q + 3'h1;
                        nvm_rd_req <= 1'b1;
                        nvm_rd_addr <= pncl_pkg::PNCL_W_LIST[(idx_q + 3'h1) * 8 +: 8];
                        state_q <= pncl_pkg::PNCL_ST_REQ;
                    end
                end
                default: begin
                    state_q <= pncl_pkg::PNCL_ST_DONE;
                end
            endcase
        end
    end

endmodule : pncl_word_fetch

// [core/pncl_loader.sv]
// Contract
// - l1 word bits 14:12 (reset 110b) become the endpoint l1 acceptable latency
// - l1 exit latency: bits 5:3 separate clock, 2:0 common clock, both 100b
// - l0s exit latency: bits 5:3 (111b) separate, bits 2:0 (101b) common
// - l0s word bits 14:12 (reset 011b) become the endpoint l0s acceptable latency
// - resend bit 4 set reissues a timed-out request; clear (default) never reissues
// - vector word bits 15:11 give table entries minus one, range 0-4, default 4
// - vector word bit 10 (default 1) becomes msi message control bit 8
// - io support bit 14 clear forces command io enable to zero, ignoring writes
// - bit 13 set (default) opens indirect access at 0x98 and 0x9c
// - bit 12 enables the serial number capability; image should hold it at 1
`timescale 1ns/1ps
module pncl_loader #(
    parameter int N_WORDS = 5
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // store read port
    output logic nvm_rd_req,
    output logic [7:0] nvm_rd_addr,
    input wire logic nvm_rd_valid,
    input wire logic [15:0] nvm_rd_data,
    // transaction layer
    input wire logic cpl_timeout,
    output logic cpl_reissue,
    // capability fields
    output logic cfg_ready,
    output logic [2:0] l1_accept_lat,
    output logic [2:0] l0s_accept_lat,
    output logic [2:0] l1_exit_lat,
    output logic [2:0] l0s_exit_lat,
    output logic [4:0] vector_count_minus_one,
    output logic msi_pv_mask,
    output logic io_bar_en,
    output logic io_access_en,
    output logic cfg_space_reg_access_en,
    output logic serial_num_en,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic word_valid;
    logic [2:0] word_idx;
    logic [15:0] word_data;
    logic load_done;

    pncl_word_fetch #(
        .N_WORDS(N_WORDS)
    ) u_fetch (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .nvm_rd_req(nvm_rd_req),
        .nvm_rd_addr(nvm_rd_addr),
        .nvm_rd_valid(nvm_rd_valid),
        .nvm_rd_data(nvm_rd_data),
        .word_valid(word_valid),
        .word_idx(word_idx),
        .word_data(word_data),
        .load_done(load_done)
    );

    // loaded fields
    logic [2:0] l1_acc_q;
    logic [2:0] l1_sep_q;
    logic [2:0] l1_com_q;
    logic [2:0] l0s_acc_q;
    logic [2:0] l0s_sep_q;
    logic [2:0] l0s_com_q;
    logic resend_q;
    logic [4:0] vec_q;
    logic msi_mask_q;
    logic io_sup_q;
    logic csr_en_q;
    logic serial_q;
    // software state
    logic common_clk_q;
    logic io_en_q;
    logic [7:0] ind_addr_q;

    // reserved bits of each word are simply never looked at
    wire [2:0] acc_fld_w = word_data[pncl_pkg::PNCL_ACC_LSB +: 3];
    wire [2:0] sep_fld_w = word_data[pncl_pkg::PNCL_SEP_LSB +: 3];
    wire [2:0] com_fld_w = word_data[pncl_pkg::PNCL_COM_LSB +: 3];
    wire [4:0] vec_raw_w = word_data[pncl_pkg::PNCL_VEC_LSB +: 5];
    // out-of-range counts would advertise a table the device lacks
    wire [4:0] vec_fld_w = (vec_raw_w > pncl_pkg::PNCL_VEC_MAX)
        ? pncl_pkg::PNCL_VEC_MAX : vec_raw_w;
    wire ld_l1_w = word_valid && (word_idx == pncl_pkg::PNCL_I_L1);
    wire ld_cpl_w = word_valid && (word_idx == pncl_pkg::PNCL_I_CPL);
    wire ld_vec_w = word_valid && (word_idx == pncl_pkg::PNCL_I_VEC);
    wire ld_l0s_w = word_valid && (word_idx == pncl_pkg::PNCL_I_L0S);
    wire ld_sup_w = word_valid && (word_idx == pncl_pkg::PNCL_I_SUP);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            l1_acc_q <= pncl_pkg::PNCL_DEF_L1_ACC;
            l1_sep_q <= pncl_pkg::PNCL_DEF_L1_SEP;
            l1_com_q <= pncl_pkg::PNCL_DEF_L1_COM;
            l0s_acc_q <= pncl_pkg::PNCL_DEF_L0S_ACC;
            l0s_sep_q <= pncl_pkg::PNCL_DEF_L0S_SEP;
            l0s_com_q <= pncl_pkg::PNCL_DEF_L0S_COM;
            resend_q <= pncl_pkg::PNCL_DEF_RESEND;
            vec_q <= pncl_pkg::PNCL_DEF_VEC;
            msi_mask_q <= pncl_pkg::PNCL_DEF_MSI_MASK;
            io_sup_q <= pncl_pkg::PNCL_DEF_IO_SUP;
            csr_en_q <= pncl_pkg::PNCL_DEF_CSR_EN;
            serial_q <= pncl_pkg::PNCL_DEF_SERIAL;
        end else begin
            if (ld_l1_w) begin
                l1_acc_q <= acc_fld_w;
                l1_sep_q <= sep_fld_w;
                l1_com_q <= com_fld_w;
            end
            if (ld_cpl_w) begin
                resend_q <= word_data[pncl_pkg::PNCL_RESEND_BIT];
            end
            if (ld_vec_w) begin
                vec_q <= vec_fld_w;
                msi_mask_q <= word_data[pncl_pkg::PNCL_MSI_MASK_BIT];
            end
            if (ld_l0s_w) begin
                l0s_acc_q <= acc_fld_w;
                l0s_sep_q <= sep_fld_w;
                l0s_com_q <= com_fld_w;
            end
            if (ld_sup_w) begin
                io_sup_q <= word_data[pncl_pkg::PNCL_IO_SUP_BIT];
                csr_en_q <= word_data[pncl_pkg::PNCL_CSR_EN_BIT];
                serial_q <= word_data[pncl_pkg::PNCL_SERIAL_BIT];
            end
        end
    end

    // exit latency follows the clock setting
    wire [2:0] l1_exit_w = common_clk_q ? l1_com_q : l1_sep_q;
    wire [2:0] l0s_exit_w = common_clk_q ? l0s_com_q : l0s_sep_q;
    wire reissue_w = cpl_timeout && resend_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfg_ready <= 1'b0;
            l1_accept_lat <= pncl_pkg::PNCL_DEF_L1_ACC;
            l0s_accept_lat <= pncl_pkg::PNCL_DEF_L0S_ACC;
            l1_exit_lat <= pncl_pkg::PNCL_DEF_L1_SEP;
            l0s_exit_lat <= pncl_pkg::PNCL_DEF_L0S_SEP;
            vector_count_minus_one <= pncl_pkg::PNCL_DEF_VEC;
            msi_pv_mask <= pncl_pkg::PNCL_DEF_MSI_MASK;
            io_bar_en <= pncl_pkg::PNCL_DEF_IO_SUP;
            io_access_en <= 1'b0;
            cfg_space_reg_access_en <= pncl_pkg::PNCL_DEF_CSR_EN;
            serial_num_en <= pncl_pkg::PNCL_DEF_SERIAL;
            cpl_reissue <= 1'b0;
        end else begin
            cfg_ready <= load_done;
            l1_accept_lat <= l1_acc_q;
            l0s_accept_lat <= l0s_acc_q;
            l1_exit_lat <= l1_exit_w;
            l0s_exit_lat <= l0s_exit_w;
            vector_count_minus_one <= vec_q;
            msi_pv_mask <= msi_mask_q;
            io_bar_en <= io_sup_q;
            io_access_en <= io_en_q;
            cfg_space_reg_access_en <= csr_en_q;
            serial_num_en <= serial_q;
            cpl_reissue <= reissue_w;
        end
    end

    // register read view, shared by the bus and the indirect window
    function automatic logic [32:0] pncl_rd_mux(input logic [7:0] addr);
        logic [32:0] r;
        r = {1'b1, 32'h00000000};
        if (addr == pncl_pkg::PNCL_A_STATUS) begin
            r = {1'b1, 31'h00000000, load_done};
        end else if (addr == pncl_pkg::PNCL_A_DEVCAP) begin
            r = {1'b1, 26'h0000000, l1_acc_q, l0s_acc_q};
        end else if (addr == pncl_pkg::PNCL_A_LINKCAP) begin
            r = {1'b1, 26'h0000000, l1_exit_w, l0s_exit_w};
        end else if (addr == pncl_pkg::PNCL_A_MISC) begin
            r = {1'b1, 22'h000000, serial_q, csr_en_q, io_sup_q, msi_mask_q, vec_q, resend_q};
        end else if (addr == pncl_pkg::PNCL_A_CTRL) begin
            r = {1'b1, 31'h00000000, common_clk_q};
        end else if (addr == pncl_pkg::PNCL_A_CMD) begin
            r = {1'b1, 31'h00000000, io_en_q};
        end else if (addr == pncl_pkg::PNCL_A_IND_ADDR) begin
            r = {1'b1, 24'h000000, ind_addr_q};
        end else if (addr == pncl_pkg::PNCL_A_IND_DATA) begin
            r = {1'b1, 32'h00000000};
        end else begin
            r = {1'b0, 32'h00000000};
        end
        return r;
    endfunction : pncl_rd_mux

    // write channel: address and data taken together, one write at a time
    wire wr_go_w = s_axi_awvalid && s_axi_wvalid && !s_axi_awready
        && !s_axi_bvalid && load_done;
    wire wr_fire_w = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
    logic [32:0] wr_look_w;
    always_comb begin
        wr_look_w = pncl_rd_mux(s_axi_awaddr);
    end
    wire wr_lane0_w = wr_fire_w && s_axi_wstrb[0];
    wire wr_ctrl_w = wr_lane0_w && (s_axi_awaddr == pncl_pkg::PNCL_A_CTRL);
    wire wr_cmd_w = wr_lane0_w && (s_axi_awaddr == pncl_pkg::PNCL_A_CMD);
    // indirect window is dead while the access path is disabled
    wire wr_ind_w = wr_lane0_w && csr_en_q
        && (s_axi_awaddr == pncl_pkg::PNCL_A_IND_ADDR);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pncl_pkg::PNCL_RESP_OKAY;
        end else begin
            s_axi_awready <= wr_go_w;
            s_axi_wready <= wr_go_w;
            if (wr_fire_w) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_look_w[32] ? pncl_pkg::PNCL_RESP_OKAY
                    : pncl_pkg::PNCL_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            common_clk_q <= pncl_pkg::PNCL_DEF_COMMON;
            io_en_q <= 1'b0;
            ind_addr_q <= 8'h00;
        end else begin
            if (wr_ctrl_w) begin
                common_clk_q <= s_axi_wdata[0];
            end
            // enable can only stick while io space is supported
            if (!io_sup_q) begin
                io_en_q <= 1'b0;
            end else if (wr_cmd_w) begin
                io_en_q <= s_axi_wdata[0];
            end
            if (wr_ind_w) begin
                ind_addr_q <= {s_axi_wdata[7:2], 2'h0};
            end
        end
    end

    // read channel
    wire rd_go_w = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid && load_done;
    wire rd_fire_w = s_axi_arready && s_axi_arvalid;
    logic [32:0] rd_look_w;
    logic [32:0] ind_look_w;
    // procedural so the view tracks field changes, not only address changes
    always_comb begin
        rd_look_w = pncl_rd_mux(s_axi_araddr);
        ind_look_w = pncl_rd_mux(ind_addr_q);
    end
    wire rd_ind_w = (s_axi_araddr == pncl_pkg::PNCL_A_IND_DATA)
        || (s_axi_araddr == pncl_pkg::PNCL_A_IND_ADDR);
    wire [31:0] ind_val_w = (s_axi_araddr == pncl_pkg::PNCL_A_IND_DATA)
        ? ind_look_w[31:0] : rd_look_w[31:0];
    // disabled window reads zero rather than erroring
    wire [31:0] rd_val_w = rd_ind_w ? (csr_en_q ? ind_val_w : 32'h00000000)
        : rd_look_w[31:0];

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= pncl_pkg::PNCL_RESP_OKAY;
        end else begin
            s_axi_arready <= rd_go_w;
            if (rd_fire_w) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val_w;
                s_axi_rresp <= rd_look_w[32] ? pncl_pkg::PNCL_RESP_OKAY
                    : pncl_pkg::PNCL_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : pncl_loader

// [testbench/pncl_store_model.sv]
`timescale 1ns/1ps
module pncl_store_model (
    // clock
    input wire logic clk_sys,
    // store read port
    input wire logic nvm_rd_req,
    input wire logic [7:0] nvm_rd_addr,
    output logic nvm_rd_valid,
    output logic [15:0] nvm_rd_data,
    // image and pacing from bench
    input wire logic [79:0] image,
    input wire logic [1:0] wait_cycles
);
    logic [1:0] cnt_q;
    logic [7:0] idx;
    // address 0x17 is not part of the image, so the upper two shift down by one
    assign idx = (nvm_rd_addr < 8'h17) ? nvm_rd_addr - 8'h14 : nvm_rd_addr - 8'h15;
    always @(posedge clk_sys) begin
        if (nvm_rd_req && !nvm_rd_valid && cnt_q >= wait_cycles) begin
            nvm_rd_valid <= 1'b1;
            nvm_rd_data <= image[idx*16 +: 16];
            cnt_q <= 2'h0;
        end else begin
            nvm_rd_valid <= 1'b0;
            // idle data toggles so a late capture cannot pass by luck
            nvm_rd_data <= ~nvm_rd_data;
            cnt_q <= nvm_rd_req ? cnt_q + 2'h1 : 2'h0;
        end
    end
endmodule : pncl_store_model

// [testbench/pncl_loader_chk.sv]
`timescale 1ns/1ps
module pncl_loader_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // store side
    input wire logic nvm_rd_req,
    input wire logic [7:0] nvm_rd_addr,
    input wire logic nvm_rd_valid,
    input wire logic [15:0] nvm_rd_data,
    // fields and bus
    input wire logic cpl_timeout,
    input wire logic cpl_reissue,
    input wire logic cfg_ready,
    input wire logic [2:0] l1_accept_lat,
    input wire logic [2:0] l0s_accept_lat,
    input wire logic [4:0] vector_count_minus_one,
    input wire logic msi_pv_mask,
    input wire logic io_bar_en,
    input wire logic io_access_en,
    input wire logic cfg_space_reg_access_en,
    input wire logic s_axi_awready,
    input wire logic s_axi_arready
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence fetch(a);
        nvm_rd_req && nvm_rd_valid && nvm_rd_addr == a;
    endsequence
    l1_accept_copy_a: assert property (fetch(8'h14) |-> ##3
        l1_accept_lat == $past(nvm_rd_data[14:12], 3)) else $error("l1 accept field wrong");
    l0s_accept_copy_a: assert property (fetch(8'h18) |-> ##3
        l0s_accept_lat == $past(nvm_rd_data[14:12], 3)) else $error("l0s accept field wrong");
    vector_clamp_a: assert property (fetch(8'h16) |-> ##3 vector_count_minus_one ==
        (($past(nvm_rd_data[15:11], 3) > 5'h04) ? 5'h04 : $past(nvm_rd_data[15:11], 3)))
        else $error("vector count wrong");
    mask_copy_a: assert property (fetch(8'h16) |-> ##3
        msi_pv_mask == $past(nvm_rd_data[10], 3)) else $error("msi mask wrong");
    csr_copy_a: assert property (fetch(8'h19) |-> ##3
        cfg_space_reg_access_en == $past(nvm_rd_data[13], 3)) else $error("csr enable wrong");
    io_lock_a: assert property (!io_bar_en |-> !io_access_en)
        else $error("io access enabled without io support");
    reissue_cause_a: assert property (cpl_reissue |-> $past(cpl_timeout))
        else $error("reissue without timeout");
    req_hold_a: assert property (nvm_rd_req && !nvm_rd_valid |=>
        nvm_rd_req && $stable(nvm_rd_addr)) else $error("store request dropped");
    early_axi_a: assert property (!cfg_ready |-> !s_axi_awready && !s_axi_arready)
        else $error("bus accepted before load");
    ready_after_a: assert property (fetch(8'h19) |-> ##[1:6] cfg_ready)
        else $error("load did not complete");
endmodule : pncl_loader_chk
bind pncl_loader pncl_loader_chk i_chk (.*);

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic nvm_rd_req, nvm_rd_valid, cpl_reissue, cfg_ready, msi_pv_mask, io_bar_en;
    logic io_access_en, cfg_space_reg_access_en, serial_num_en;
    logic [7:0] nvm_rd_addr;
    logic [15:0] nvm_rd_data;
    logic [2:0] l1_accept_lat, l0s_accept_lat, l1_exit_lat, l0s_exit_lat;
    logic [4:0] vector_count_minus_one;
    logic cpl_timeout = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [79:0] image = 80'h0;
    logic [1:0] wait_cycles = 2'h0;
    logic [15:0] lfsr_q = 16'h005b;
    int miscompares = 0, samples_checked = 0, fetches = 0;
    always #5 clk_sys = ~clk_sys;
    pncl_loader #(.N_WORDS(5)) i_dut (.*);
    pncl_store_model i_store (.*);
    always @(posedge clk_sys) begin
        if (nvm_rd_req && nvm_rd_valid) fetches++;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    task automatic bound(input int n);
        if (n >= 200) begin
            miscompares++;
            report_and_stop();
        end
    endtask : bound
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 200);
        s_axi_bready <= 1'b0;
        bound(n);
        check(s_axi_bresp, er);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
        int n;
        n = 0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 200);
        s_axi_rready <= 1'b0;
        bound(n);
        check({s_axi_rresp, s_axi_rdata[29:0]}, {er, ed[29:0]});
    endtask : axi_rd
    initial begin
        logic [15:0] w [5];
        logic [4:0] vec;
        logic [31:0] misc, lc_sep, lc_com, dc;
        int n;
        for (int p = 0; p < 4; p++) begin
            for (int i = 0; i < 5; i++) begin
                lfsr_q = lfsr_next(lfsr_q);
                w[i] = lfsr_q;
            end
            w[4][14] = p[0];
            w[4][13] = p[1];
            w[4][12] = 1'b1;
            w[1][4] = p[0] ^ p[1];
            image <= {w[4], w[3], w[2], w[1], w[0]};
            wait_cycles <= p[1:0];
            reset_n <= 1'b0;
            repeat (10) @(posedge clk_sys);
            fetches = 0;
            check({l1_accept_lat, l0s_accept_lat, l1_exit_lat, l0s_exit_lat},
                12'hce7);
            check({vector_count_minus_one, msi_pv_mask, cfg_space_reg_access_en, serial_num_en,
                io_bar_en, io_access_en, cfg_ready}, 11'h13c);
            reset_n <= 1'b1;
            // read offered during the load must wait for it and then see it done
            axi_rd(8'h00, 2'h0, 32'h1);
            n = 0;
            do begin
                @(posedge clk_sys);
                n++;
            end while (!cfg_ready && n < 200);
            bound(n);
            vec = (w[2][15:11] > 5'h04) ? 5'h04 : w[2][15:11];
            misc = {w[4][12], w[4][13], w[4][14], w[2][10], vec, w[1][4]};
            lc_sep = {w[0][5:3], w[3][5:3]};
            lc_com = {w[0][2:0], w[3][2:0]};
            dc = {w[0][14:12], w[3][14:12]};
            check({l1_accept_lat, l0s_accept_lat, l1_exit_lat, l0s_exit_lat},
                {dc[5:0], lc_sep[5:0]});
            check({serial_num_en, cfg_space_reg_access_en, io_bar_en, msi_pv_mask,
                vector_count_minus_one}, misc[9:1]);
            axi_rd(8'h00, 2'h0, 32'h1);
            axi_rd(8'h04, 2'h0, dc);
            axi_rd(8'h08, 2'h0, lc_sep);
            axi_rd(8'h0c, 2'h0, misc);
            axi_wr(8'h10, 32'h1, 2'h0);
            // low byte lane off: the clock select must not move back
            s_axi_wstrb <= 4'he;
            axi_wr(8'h10, 32'h0, 2'h0);
            s_axi_wstrb <= 4'hf;
            axi_wr(8'h14, 32'h1, 2'h0);
            axi_rd(8'h08, 2'h0, lc_com);
            axi_rd(8'h14, 2'h0, {31'h0, w[4][14]});
            check({l1_exit_lat, l0s_exit_lat, io_access_en},
                {lc_com[5:0], w[4][14]});
            axi_wr(8'h98, 32'h4, 2'h0);
            axi_rd(8'h9c, 2'h0, w[4][13] ? dc : 32'h0);
            axi_rd(8'h40, 2'h2, 32'h0);
            axi_wr(8'h40, 32'h1, 2'h2);
            @(posedge clk_sys);
            cpl_timeout <= 1'b1;
            @(posedge clk_sys);
            cpl_timeout <= 1'b0;
            @(posedge clk_sys);
            check(cpl_reissue, w[1][4]);
            check(fetches, 5);
        end
        report_and_stop();
    end
endmodule : testbench
